// ===== verilog/fic_pkg.sv
// package of constants and types for the flash id and security command decoder
package fic_pkg;
  // opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h38;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
  localparam logic [7:0] OP_READ_IDENT = 8'h9F;
  localparam logic [7:0] OP_READ_SIGNATURE = 8'hAB;
  localparam logic [7:0] OP_READ_MAKER_PART = 8'h90;
  localparam logic [7:0] OP_READ_MAKER_PART_DUAL = 8'hEF;
  localparam logic [7:0] OP_READ_MAKER_PART_QUAD = 8'hDF;
  localparam logic [7:0] OP_ENTER_OTP = 8'hB1;
  localparam logic [7:0] OP_EXIT_OTP = 8'hC1;
  localparam logic [7:0] OP_READ_SECURITY_REG = 8'h2B;
  localparam logic [7:0] OP_WRITE_SECURITY_REG = 8'h2F;
  localparam logic [7:0] OP_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] OP_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] OP_READ_LOCK_STATE = 8'h3C;
  localparam logic [7:0] OP_GANG_LOCK = 8'h7E;
  localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
  localparam logic [7:0] OP_PROTECT_SELECT = 8'h68;
  localparam logic [7:0] OP_READ_PARAM_TABLE = 8'h5A;
  // identity bytes, values arbitrary
  localparam logic [7:0] MAKER_CODE = 8'h5E;
  localparam logic [7:0] PART_TYPE_CODE = 8'h3A;
  localparam logic [7:0] PART_CAP_CODE = 8'h14;
  // bit counts of command phases
  localparam logic [5:0] BITS_OPCODE = 6'h08;
  localparam logic [5:0] BITS_ADDR = 6'h18;
  localparam logic [5:0] BITS_IDENT = 6'h18;
  // status bit positions
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_LATCH_POS = 1;
  // sector/block address width kept for lock requests
  localparam int ADDR_W = 24;
  // reset values
  localparam logic RST_LATCH = 1'b0;
  localparam logic RST_OTP = 1'b0;
  localparam logic [7:0] RST_SHIFT = 8'h00;

  // command bound for the core; pulse fields are one clk cycle long
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
    logic hasAddr;
    logic byteAligned;
  } fic_cmd_t;

  // one-cycle requests to the array side
  typedef struct packed {
    logic progErase;
    logic statusWrite;
    logic singleLock;
    logic singleUnlock;
    logic gangLock;
    logic gangUnlock;
    logic secWrite;
    logic protSelect;
    logic [ADDR_W-1:0] addr;
  } fic_req_t;

  // true for opcodes that need the write latch
  function automatic logic fic_needs_latch(input logic [7:0] op);
    case (op)
      OP_WRITE_STATUS, OP_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE,
      OP_BLOCK_ERASE, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_WRITE_SECURITY_REG, OP_SINGLE_LOCK,
      OP_SINGLE_UNLOCK, OP_GANG_LOCK, OP_GANG_UNLOCK, OP_PROTECT_SELECT: fic_needs_latch = 1'b1;
      default: fic_needs_latch = 1'b0;
    endcase
  endfunction : fic_needs_latch
endpackage : fic_pkg

// ===== verilog/fic_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module fic_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic stage1;

  // stage1 feeds dout only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : fic_sync

// ===== verilog/fic_link.sv
// serial link end: shifts bits on the serial clock, hands each opcode to clk by toggle after its eighth bit
`timescale 1ns/1ps
module fic_link
  import fic_pkg::*;
(
  input wire logic sclk,
  input wire logic csN,
  input wire logic holdN,
  input wire logic si,
  input wire logic [23:0] txWord,
  input wire logic [5:0] txBits,
  input wire logic txLoad,
  output logic [7:0] opcode,
  output logic [31:0] rxShift,
  output logic [5:0] rxCount,
  output logic opToggle,
  output logic so,
  output logic soEn
);
  logic [23:0] txShift;
  logic [5:0] txLeft;
  logic [8:0] bitCnt;

  // rising edge capture; chip select high clears at once
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt <= 9'h000;
      rxShift <= 32'h00000000;
      opcode <= 8'h00;
      opToggle <= 1'b0; // flag is per frame; a held value would leave it unknown after power-up
    end else if (holdN) begin
      rxShift <= {rxShift[30:0], si}; // msb first
      if (bitCnt != 9'h1FF) bitCnt <= bitCnt + 9'h001;
      if (bitCnt == 9'h007) begin
        opcode <= {rxShift[6:0], si};
        opToggle <= ~opToggle;
      end
    end
  end

  // bits since chip select fell, opcode included, saturating at 63
  assign rxCount = (bitCnt > 9'h03F) ? 6'h3F : 6'(bitCnt);

  // falling edge drive; reply word loaded combinationally from the core
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      txShift <= 24'h000000;
      txLeft <= 6'h00;
      so <= 1'b0;
      soEn <= 1'b0; // output released at chip select rise
    end else if (holdN) begin
      if (txLoad && txLeft == 6'h00) begin
        so <= txWord[23];
        txShift <= {txWord[22:0], 1'b0};
        txLeft <= txBits - 6'h01;
        soEn <= 1'b1; // bits leave on falling edges
      end else if (txLeft != 6'h00) begin
        so <= txShift[23];
        txShift <= {txShift[22:0], 1'b0};
        txLeft <= txLeft - 6'h01;
      end
    end else begin
      soEn <= 1'b0;
    end
  end
endmodule : fic_link

// ===== verilog/fic_decoder.sv
// command decoder for identification, otp, lock, protect-select, write latch and status read
`timescale 1ns/1ps
module fic_decoder
  import fic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic csN,
  input wire logic holdN,
  input wire logic si,
  output logic so,
  output logic soEn,
  input wire logic arrayBusy,
  input wire logic arrayDone,
  input wire logic [7:0] statusUpper,
  input wire logic [7:0] securityReg,
  input wire logic lockState,
  input wire logic [7:0] paramData,
  output logic [7:0] paramAddr,
  output fic_req_t arrayReq,
  output logic otpMode,
  output logic writeLatchFlag,
  output logic busyFlag,
  output logic secLockDown,
  output logic blockProtMode
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    FIC_IDLE = 2'b00,
    FIC_CMD = 2'b01,
    FIC_REPLY = 2'b11,
    FIC_ENDED = 2'b10
  } fic_state_t;

  fic_state_t state;
  logic [7:0] opcode;
  logic [31:0] rxShift;
  logic [5:0] rxCount;
  logic opToggle;
  logic opToggleSync;
  logic opSeen;
  logic csHighSync;
  logic holdActiveSync;
  logic [23:0] txWord;
  logic [5:0] txBits;
  logic txLoad;
  logic [7:0] heldOp;
  logic [31:0] heldShift;
  logic [5:0] heldCount;
  logic [31:0] shiftSync1;
  logic [31:0] shiftSync2;
  logic [5:0] countSync1;
  logic [5:0] countSync2;
  logic [7:0] opSync1;
  logic [7:0] opSync2;
  logic progRunning;
  logic [7:0] statusByte;
  logic latchOk;
  logic doneFlag;

  ////////////////////////////////////////////////////////////////////////////
  // serial end on its own clock
  fic_link u_link (
    .sclk(sclk),
    .csN(csN),
    .holdN(holdN),
    .si(si),
    .txWord(txWord),
    .txBits(txBits),
    .txLoad(txLoad),
    .opcode(opcode),
    .rxShift(rxShift),
    .rxCount(rxCount),
    .opToggle(opToggle),
    .so(so),
    .soEn(soEn)
  );

  // toggle crossing for the opcode event
  fic_sync u_opsync (
    .clk(clk),
    .rst_n(rst_n),
    .din(opToggle),
    .dout(opToggleSync)
  );

  // chip select level into clk domain
  fic_sync u_cssync (
    .clk(clk),
    .rst_n(rst_n),
    .din(csN),
    .dout(csHighSync)
  );

  // hold level into clk domain, high while the host holds the link
  fic_sync u_holdsync (
    .clk(clk),
    .rst_n(rst_n),
    .din(!holdN),
    .dout(holdActiveSync)
  );

  // captured words: the link clears them as chip select rises, so only copies taken while it is low count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shiftSync1 <= 32'h00000000;
      shiftSync2 <= 32'h00000000;
      countSync1 <= 6'h00;
      countSync2 <= 6'h00;
      opSync1 <= 8'h00;
      opSync2 <= 8'h00;
    end else begin
      shiftSync1 <= rxShift;
      shiftSync2 <= shiftSync1;
      countSync1 <= rxCount;
      countSync2 <= countSync1;
      opSync1 <= opcode;
      opSync2 <= opSync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply word: combinational on stable opcode; status read is sampled live
  assign progRunning = arrayBusy;
  assign busyFlag = arrayBusy;
  assign statusByte = {statusUpper[7:2], writeLatchFlag, busyFlag};
  assign paramAddr = rxShift[15:8]; // low address byte sits above the dummy byte at load

  always_comb begin
    txWord = 24'h000000;
    txBits = 6'h00;
    txLoad = 1'b0;
    case (opcode)
      OP_READ_IDENT: begin
        if (!progRunning && rxCount == BITS_OPCODE) begin
          txWord = {MAKER_CODE, PART_TYPE_CODE, PART_CAP_CODE};
          txBits = BITS_IDENT;
          txLoad = 1'b1;
        end
      end
      OP_READ_STATUS: begin
        txWord = {statusByte, 16'h0000};
        txBits = 6'h08;
        txLoad = (rxCount >= BITS_OPCODE); // repeats until cs rises
      end
      OP_READ_SECURITY_REG: begin
        txWord = {securityReg, 16'h0000};
        txBits = 6'h08;
        txLoad = (rxCount >= BITS_OPCODE);
      end
      OP_READ_SIGNATURE: begin
        txWord = {PART_CAP_CODE, 16'h0000};
        txBits = 6'h08;
        txLoad = (rxCount >= BITS_OPCODE + BITS_ADDR);
      end
      OP_READ_MAKER_PART, OP_READ_MAKER_PART_DUAL, OP_READ_MAKER_PART_QUAD: begin
        txWord = rxShift[0] ? {PART_CAP_CODE, MAKER_CODE, 8'h00} : {MAKER_CODE, PART_CAP_CODE, 8'h00};
        txBits = 6'h10;
        txLoad = (rxCount >= BITS_OPCODE + BITS_ADDR);
      end
      OP_READ_LOCK_STATE: begin
        txWord = {{8{lockState}}, 16'h0000};
        txBits = 6'h08;
        txLoad = (rxCount == BITS_OPCODE + BITS_ADDR);
      end
      OP_READ_PARAM_TABLE: begin
        txWord = {paramData, 16'h0000};
        txBits = 6'h08;
        txLoad = (rxCount == BITS_OPCODE + BITS_ADDR + 6'h08);
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking on clk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opSeen <= 1'b0;
    end else begin
      opSeen <= opToggleSync;
    end
  end

  // frame state; cs rise always returns to idle, hold included
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= FIC_IDLE;
      heldOp <= RST_SHIFT;
      heldShift <= 32'h00000000;
      heldCount <= 6'h00;
    end else begin
      case (state)
        FIC_IDLE: if (!csHighSync) state <= FIC_CMD;
        FIC_CMD: begin
          if (opSeen != opToggleSync) state <= FIC_REPLY;
          else if (csHighSync) state <= FIC_IDLE;
        end
        FIC_REPLY: begin
          if (!csHighSync) begin
            // newest copy wins; the one taken just before the rise is the whole frame
            heldOp <= opSync2;
            heldShift <= shiftSync2;
            heldCount <= countSync2;
          end else if (holdActiveSync) begin
            state <= FIC_IDLE; // rise under hold drops the command
          end else begin
            state <= FIC_ENDED;
          end
        end
        FIC_ENDED: state <= FIC_IDLE;
        default: state <= FIC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write latch rules on the completed frame
  assign latchOk = writeLatchFlag && !arrayBusy;
  assign doneFlag = (state == FIC_ENDED);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      writeLatchFlag <= RST_LATCH;
    end else if (doneFlag && heldCount == BITS_OPCODE && heldOp == OP_WRITE_ENABLE) begin
      writeLatchFlag <= 1'b1; // set wins over a coincident completion
    end else if (arrayDone) begin
      writeLatchFlag <= 1'b0; // cleared when any modifying cycle ends
    end else if (doneFlag && heldCount == BITS_OPCODE && heldOp == OP_WRITE_DISABLE) begin
      writeLatchFlag <= 1'b0;
    end
  end

  // one-cycle requests; rejected without the latch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arrayReq <= '0;
    end else begin
      arrayReq <= '0;
      arrayReq.addr <= heldShift[ADDR_W-1:0];
      if (doneFlag && latchOk && fic_needs_latch(heldOp)) begin
        case (heldOp)
          OP_SINGLE_LOCK: arrayReq.singleLock <= (heldCount == BITS_OPCODE + BITS_ADDR);
          OP_SINGLE_UNLOCK: arrayReq.singleUnlock <= (heldCount == BITS_OPCODE + BITS_ADDR);
          OP_GANG_LOCK: arrayReq.gangLock <= (heldCount == BITS_OPCODE);
          OP_GANG_UNLOCK: arrayReq.gangUnlock <= (heldCount == BITS_OPCODE);
          OP_WRITE_SECURITY_REG: arrayReq.secWrite <= (heldCount == BITS_OPCODE);
          OP_PROTECT_SELECT: arrayReq.protSelect <= (heldCount == BITS_OPCODE);
          OP_WRITE_STATUS: arrayReq.statusWrite <= (heldCount == 6'h10); // opcode plus exactly one data byte only
          default: arrayReq.progErase <= (heldCount[2:0] == 3'h0);
        endcase
      end
    end
  end

  // mode bits set by completed frames
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      otpMode <= RST_OTP;
      secLockDown <= 1'b0;
      blockProtMode <= 1'b0;
    end else if (doneFlag && heldCount == BITS_OPCODE && !arrayBusy) begin
      if (heldOp == OP_ENTER_OTP) otpMode <= 1'b1;
      if (heldOp == OP_EXIT_OTP) otpMode <= 1'b0;
      if (heldOp == OP_WRITE_SECURITY_REG && writeLatchFlag) secLockDown <= 1'b1;
      if (heldOp == OP_PROTECT_SELECT && writeLatchFlag) blockProtMode <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_latch_rejects: assert property (@(posedge clk) disable iff (!rst_n)
    (doneFlag && !writeLatchFlag) |=> (arrayReq.gangLock == 1'b0 && arrayReq.protSelect == 1'b0))
    else $error("request issued without latch");
  a_write_enable_cmd_sets: assert property (@(posedge clk) disable iff (!rst_n)
    (doneFlag && heldOp == OP_WRITE_ENABLE && heldCount == BITS_OPCODE) |=> writeLatchFlag)
    else $error("write enable did not set latch");
  a_write_disable_cmd_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (doneFlag && heldOp == OP_WRITE_DISABLE && heldCount == BITS_OPCODE) |=> !writeLatchFlag)
    else $error("write disable did not clear latch");
  a_done_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (arrayDone && !(doneFlag && heldOp == OP_WRITE_ENABLE && heldCount == BITS_OPCODE)) |=> !writeLatchFlag)
    else $error("latch stayed after completion");
  a_busy_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    busyFlag == arrayBusy)
    else $error("busy flag wrong");
  a_otp_enter: assert property (@(posedge clk) disable iff (!rst_n)
    (doneFlag && heldOp == OP_ENTER_OTP && heldCount == BITS_OPCODE && !arrayBusy) |=> otpMode)
    else $error("otp mode not entered");
  a_otp_exit: assert property (@(posedge clk) disable iff (!rst_n)
    (doneFlag && heldOp == OP_EXIT_OTP && heldCount == BITS_OPCODE && !arrayBusy) |=> !otpMode)
    else $error("otp mode not left");
  a_frame_end: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FIC_REPLY && csHighSync && !holdActiveSync) |=> state == FIC_ENDED ##1 state == FIC_IDLE)
    else $error("no standby after frame");
  a_hold_abort: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FIC_REPLY && csHighSync && holdActiveSync) |=> state == FIC_IDLE)
    else $error("held frame not dropped");
  a_secure_lock: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(secLockDown) |-> $past(writeLatchFlag))
    else $error("lock-down without latch");
  c_write_enable_cmd: cover property (@(posedge clk) disable iff (!rst_n) $rose(writeLatchFlag));
  c_otp: cover property (@(posedge clk) disable iff (!rst_n) $rose(otpMode));
  c_gang: cover property (@(posedge clk) disable iff (!rst_n) arrayReq.gangLock);
  c_single: cover property (@(posedge clk) disable iff (!rst_n) arrayReq.singleLock);
  c_hold: cover property (@(posedge clk) disable iff (!rst_n) state == FIC_REPLY && csHighSync && holdActiveSync);
endmodule : fic_decoder

// ===== dv/fic_host_model.sv
// host side model: serial frames in mode 0, reply capture
`timescale 1ns/1ps
module fic_host_model (
  output logic sclk,
  output logic csN,
  output logic holdN,
  output logic si,
  input wire logic so,
  input wire logic soEn
);
  logic drove;

  // serial clock idles low, only toggles inside a frame
  initial begin
    sclk = 1'b0;
    csN = 1'b0;
    holdN = 1'b1;
    si = 1'b0;
    drove = 1'b0;
    // one clean rise of chip select clears the link end before any frame
    #1 csN = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // one frame: only defined opcodes, dummy bytes sent whole
  // cs may rise mid readout to end it early each command is its own frame
  task automatic xfer(input logic [31:0] tx, input int txN, input int rxN, input bit holdEnd,
                      output logic [23:0] rx);
    int i;
    rx = 24'h000000;
    drove = 1'b0;
    #3 csN = 1'b0;
    for (i = 0; i < txN + rxN; i++) begin
      // msb first; a released input toggles so no stale level survives
      if (i < txN) si = tx[txN-1-i];
      else si = ~si;
      #16 sclk = 1'b1;
      if (i >= txN) rx = {rx[22:0], so};
      drove = drove | soEn;
      #16 sclk = 1'b0;
    end
    // hold taken while sclk low, then cs rise aborts the command
    if (holdEnd) #5 holdN = 1'b0;
    #8 csN = 1'b1;
    #60 holdN = 1'b1;
  endtask : xfer
endmodule : fic_host_model

// ===== dv/fic_decoder_tb_top.sv
// self-checking testbench of the command decoder
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module fic_decoder_tb_top
  import fic_pkg::*;
;
  logic clk, rst_n, sclk, csN, holdN, si, so, soEn;
  logic arrayBusy, arrayDone, lockState, clrSeen;
  logic otpMode, writeLatchFlag, busyFlag, secLockDown, blockProtMode;
  logic [7:0] statusUpper, securityReg, paramData, paramAddr, reqSeen;
  logic [23:0] rx, lastAddr;
  fic_req_t arrayReq;
  int fails, num_checks;

  fic_decoder uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .holdN(holdN), .si(si),
    .so(so), .soEn(soEn), .arrayBusy(arrayBusy), .arrayDone(arrayDone), .statusUpper(statusUpper),
    .securityReg(securityReg), .lockState(lockState), .paramData(paramData), .paramAddr(paramAddr),
    .arrayReq(arrayReq), .otpMode(otpMode), .writeLatchFlag(writeLatchFlag), .busyFlag(busyFlag),
    .secLockDown(secLockDown), .blockProtMode(blockProtMode));
  fic_host_model host (.sclk(sclk), .csN(csN), .holdN(holdN), .si(si), .so(so), .soEn(soEn));

  // table byte is the inverted address, easy to predict
  assign paramData = ~paramAddr;
  always #2.5 clk = ~clk;

  // pulses last one clk, so collect them sticky
  always @(posedge clk) begin
    if (clrSeen) reqSeen <= 8'h00;
    else reqSeen <= reqSeen | arrayReq[31:24];
    if (|arrayReq[31:24]) lastAddr <= arrayReq.addr;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // whole write-only frame of n bits, then settle past the crossing
  task automatic cmd(input logic [31:0] w, input int n);
    host.xfer(w, n, 0, 1'b0, rx);
    cyc(12);
  endtask : cmd

  task automatic done_pulse();
    arrayDone = 1'b1;
    cyc(1);
    arrayDone = 1'b0;
    cyc(4);
  endtask : done_pulse

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    `CHK("latch at reset", 1'b0, writeLatchFlag)
    `CHK("otp at reset", 1'b0, otpMode)
    cmd({24'h000000, OP_WRITE_ENABLE}, 8);
    `CHK("latch set", 1'b1, writeLatchFlag)
    cmd({24'h000000, OP_WRITE_DISABLE}, 8);
    `CHK("latch clear", 1'b0, writeLatchFlag)
    $display("test latch done");
  endtask : t_latch

  // full id, aborted id, then a clean id again from standby
  task automatic t_ident();
    host.xfer({24'h000000, OP_READ_IDENT}, 8, 24, 1'b0, rx);
    `CHK("ident", {MAKER_CODE, PART_TYPE_CODE, PART_CAP_CODE}, rx)
    host.xfer({24'h000000, OP_READ_IDENT}, 8, 10, 1'b0, rx);
    cyc(2);
    `CHK("abort bits", {MAKER_CODE, PART_TYPE_CODE[7:6]}, rx[9:0])
    `CHK("abort release", 1'b0, soEn)
    cyc(12);
    host.xfer({24'h000000, OP_READ_IDENT}, 8, 24, 1'b0, rx);
    `CHK("ident again", {MAKER_CODE, PART_TYPE_CODE, PART_CAP_CODE}, rx)
    arrayBusy = 1'b1;
    cyc(12);
    `CHK("busy flag", 1'b1, busyFlag)
    host.xfer({24'h000000, OP_READ_IDENT}, 8, 24, 1'b0, rx);
    `CHK("ident when busy", 1'b0, host.drove)
    arrayBusy = 1'b0;
    cyc(12);
    `CHK("busy idle", 1'b0, busyFlag)
    $display("test ident done");
  endtask : t_ident

  // every maker/part variant with both selectors
  task automatic t_maker();
    logic [7:0] ops [3];
    int i, s;
    ops = '{OP_READ_MAKER_PART, OP_READ_MAKER_PART_DUAL, OP_READ_MAKER_PART_QUAD};
    for (i = 0; i < 3; i++) begin
      for (s = 0; s < 2; s++) begin
        host.xfer({ops[i], 16'h0000, 7'h00, s[0]}, 32, 16, 1'b0, rx);
        `CHK("maker byte", MAKER_CODE, (s == 0) ? rx[15:8] : rx[7:0])
        cyc(12);
      end
    end
    host.xfer({OP_READ_SIGNATURE, 24'h000000}, 32, 8, 1'b0, rx);
    `CHK("signature reply", 1'b1, host.drove)
    cyc(12);
    $display("test maker done");
  endtask : t_maker

  task automatic t_otp();
    cmd({24'h000000, OP_ENTER_OTP}, 8);
    `CHK("otp on", 1'b1, otpMode)
    cmd({24'h000000, OP_EXIT_OTP}, 8);
    `CHK("otp off", 1'b0, otpMode)
    $display("test otp done");
  endtask : t_otp

  // refused without latch, then seven modifiers, each after a write enable
  task automatic t_modify();
    logic [7:0] ops [7];
    int bits [7];
    int i;
    ops = '{OP_SINGLE_LOCK, OP_SINGLE_UNLOCK, OP_GANG_LOCK, OP_GANG_UNLOCK, OP_WRITE_SECURITY_REG,
            OP_PROTECT_SELECT, OP_SECTOR_ERASE};
    bits = '{5, 4, 3, 2, 1, 0, 7};
    clrSeen = 1'b1;
    cyc(1);
    clrSeen = 1'b0;
    cmd({24'h000000, OP_GANG_LOCK}, 8);
    `CHK("refused", 8'h00, reqSeen)
    for (i = 0; i < 7; i++) begin
      cmd({24'h000000, OP_WRITE_ENABLE}, 8);
      clrSeen = 1'b1;
      cyc(1);
      clrSeen = 1'b0;
      if (i < 2 || i == 6) cmd({ops[i], 24'hA5C3F0}, 32);
      else cmd({24'h000000, ops[i]}, 8);
      `CHK("request", 8'h01 << bits[i], reqSeen)
      if (i < 2) `CHK("lock addr", 24'hA5C3F0, lastAddr)
      done_pulse();
      `CHK("latch done", 1'b0, writeLatchFlag)
    end
    `CHK("lock down", 1'b1, secLockDown)
    `CHK("prot mode", 1'b1, blockProtMode)
    $display("test modify done");
  endtask : t_modify

  // status twice in one frame while busy, latch and busy in low bits
  task automatic t_status();
    cmd({24'h000000, OP_WRITE_ENABLE}, 8);
    arrayBusy = 1'b1;
    statusUpper = 8'hA4;
    cyc(12);
    host.xfer({24'h000000, OP_READ_STATUS}, 8, 16, 1'b0, rx);
    `CHK("status", {2{statusUpper[7:2], 2'h3}}, rx[15:0])
    arrayBusy = 1'b0;
    cyc(12);
    host.xfer({24'h000000, OP_READ_STATUS}, 8, 8, 1'b0, rx);
    `CHK("busy polled clear", 2'h2, rx[1:0])
    cmd({24'h000000, OP_WRITE_DISABLE}, 8);
    host.xfer({24'h000000, OP_WRITE_ENABLE}, 8, 0, 1'b1, rx);
    cyc(12);
    `CHK("hold abort", 1'b0, writeLatchFlag)
    $display("test status done");
  endtask : t_status

  task automatic t_reads();
    securityReg = 8'h3C;
    lockState = 1'b1;
    cyc(12);
    host.xfer({24'h000000, OP_READ_SECURITY_REG}, 8, 8, 1'b0, rx);
    `CHK("security read", 8'h3C, rx[7:0])
    cyc(12);
    host.xfer({OP_READ_LOCK_STATE, 24'h010000}, 32, 8, 1'b0, rx);
    `CHK("lock read", 8'hFF, rx[7:0])
    cyc(12);
    host.xfer({OP_READ_PARAM_TABLE, 24'h000017}, 32, 16, 1'b0, rx);
    `CHK("param read", 8'hE8, rx[7:0])
    cyc(12);
    $display("test reads done");
  endtask : t_reads

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    arrayBusy = 1'b0;
    arrayDone = 1'b0;
    statusUpper = 8'h00;
    securityReg = 8'h00;
    lockState = 1'b0;
    clrSeen = 1'b1;
    fails = 0;
    num_checks = 0;
    cyc(20);
    rst_n = 1'b1;
    clrSeen = 1'b0;
    cyc(4);
    t_latch();
    t_ident();
    t_maker();
    t_otp();
    t_modify();
    t_status();
    t_reads();
    complete_run();
  end

  // about 80k clk, well past the expected run length
  initial begin
    #400000;
    fails++;
    complete_run();
  end
endmodule : fic_decoder_tb_top
